// [core/pwm_fault_retrigger_inputs.sv]
// Stage controller input module: retrigger/fault handling with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pwm_input_defs.svh"

// Function
// - Centered mode ignores all retrigger events
// - Two/four ramp: retrigger jumps to opposite half
// - One ramp: retrigger restarts counter at zero
// - Input A can release output A early
// - Input B can release output B early
// - Each input from comparator or pin
// - Optional four-tick digital input filter
// - Async control kills outputs without clock
// - Polarity bit selects active edge/level
// - Two/four ramp: input evaluated own half only
// - One ramp: inputs evaluated whole ramp
// - Four-bit mode field, reserved codes inert
// - Mode 1 A: release, wait, then B
// - Mode 1 B: release, wait, then A
// - Mode 2 A: run B half, then wait
// - Mode 2 B: run A half, then wait
// - Mode 3 A: repeat B half while active
// - Mode 3 B: repeat A half while active
// - Mode 4 forces outputs off, timing continues
module pwm_fault_retrigger_inputs #(
  parameter int CNT_W   = 12,
  parameter int PRESC_W = 8
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Fault/retrigger sources
  input  wire logic        fault_input_pin_a,
  input  wire logic        fault_input_pin_b,
  input  wire logic        comparator_a,
  input  wire logic        comparator_b,
  // Stage outputs
  output logic             output_a_pin,
  output logic             output_b_pin
);

  // Register storage
  logic [31:0] input_control_reg_a, input_control_reg_b, run_reg, time_a, time_b;
  // Bus slave state
  logic              aw_full, w_full;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  // Sequencer state
  pwm_input_pkg::phase_type phase, next_phase;
  logic [CNT_W-1:0]         cnt, next_cnt;
  logic                     pend_a, pend_b, burst_a, burst_b;
  logic                     next_pend_a, next_pend_b, next_burst_a, next_burst_b;
  logic [PRESC_W-1:0]       div;
  logic                     out_a, out_b;
  // Conditioned inputs
  logic act_a, act_b, rise_a, rise_b, raw_a, raw_b;

  // Byte-lane merge, shared by all writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Retrigger-capable mode codes; everything else is inert here
  function automatic logic retrig_mode(input logic [3:0] m);
    retrig_mode = (m == `MODE_JUMP_WAIT) || (m == `MODE_RUN_WAIT) ||
                  (m == `MODE_BURST) || (m == `MODE_EDGE_RETRIG);
  endfunction

  // Configuration decode
  wire pwm_input_pkg::chan_cfg_type cfg_a =
    pwm_input_pkg::chan_cfg_type'(input_control_reg_a[`CFG_MSB:0]);
  wire pwm_input_pkg::chan_cfg_type cfg_b =
    pwm_input_pkg::chan_cfg_type'(input_control_reg_b[`CFG_MSB:0]);
  wire pwm_input_pkg::run_mode_type rmode =
    pwm_input_pkg::run_mode_type'(run_reg[`RUN_MODE_MSB:`RUN_MODE_LSB]);
  wire               run_on   = run_reg[`RUN_EN_BIT];
  wire [PRESC_W-1:0] presc    = run_reg[`PRESC_MSB:`PRESC_LSB];
  wire               one_ramp = (rmode == pwm_input_pkg::RUN_ONE_RAMP);
  wire               centered = (rmode == pwm_input_pkg::RUN_CENTERED);

  // Stage clock enable from the prescaler
  wire tick = (div == presc);

  // Input conditioning per half
  input_conditioner #(.FILTER_LEN(`FILTER_CYCLES)) cond_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .pin       (fault_input_pin_a),
    .comparator(comparator_a),
    .src_sel   (cfg_a.src_cmp),
    .filter_en (cfg_a.filter_en),
    .level_sel (cfg_a.level_high),
    .active    (act_a),
    .rise      (rise_a),
    .raw_active(raw_a)
  );
  input_conditioner #(.FILTER_LEN(`FILTER_CYCLES)) cond_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .pin       (fault_input_pin_b),
    .comparator(comparator_b),
    .src_sel   (cfg_b.src_cmp),
    .filter_en (cfg_b.filter_en),
    .level_sel (cfg_b.level_high),
    .active    (act_b),
    .rise      (rise_b),
    .raw_active(raw_b)
  );

  // Phase length and window decode
  wire [CNT_W-1:0] cur_len =
    (phase == pwm_input_pkg::ST_DT_A) ? time_a[`DEAD_MSB:`DEAD_LSB] :
    (phase == pwm_input_pkg::ST_OT_A) ? time_a[`ON_MSB:`ON_LSB] :
    (phase == pwm_input_pkg::ST_DT_B) ? time_b[`DEAD_MSB:`DEAD_LSB] :
                                        time_b[`ON_MSB:`ON_LSB];
  wire end_phase = (cnt >= cur_len);
  wire in_run    = !phase[2];
  wire half_a    = (phase == pwm_input_pkg::ST_DT_A) || (phase == pwm_input_pkg::ST_OT_A);
  wire half_b    = (phase == pwm_input_pkg::ST_DT_B) || (phase == pwm_input_pkg::ST_OT_B);
  wire win_a     = one_ramp || centered || half_a;
  wire win_b     = one_ramp || centered || half_b;
  // Edge mode acts on the significant edge, the others on level
  wire trig_a = (cfg_a.mode == `MODE_EDGE_RETRIG) ? rise_a : act_a;
  wire trig_b = (cfg_b.mode == `MODE_EDGE_RETRIG) ? rise_b : act_b;
  // Events; reserved and unlisted codes never qualify
  wire evt_a = run_on && tick && in_run && retrig_mode(cfg_a.mode) && trig_a && win_a &&
               !centered && !pend_a && !burst_a;
  wire evt_b = run_on && tick && in_run && retrig_mode(cfg_b.mode) && trig_b && win_b &&
               !centered && !pend_b && !burst_b && !evt_a;
  // Mode 4 blanks both outputs, timing untouched
  wire force_off = (cfg_a.mode == `MODE_FORCE_OFF && act_a && win_a) ||
                   (cfg_b.mode == `MODE_FORCE_OFF && act_b && win_b);

  // Sequencer next state; A has priority when both fire together
  always_comb begin
    next_phase   = phase;
    next_cnt     = cnt;
    next_pend_a  = pend_a;
    next_pend_b  = pend_b;
    next_burst_a = burst_a;
    next_burst_b = burst_b;
    if (!run_on) begin
      next_phase   = pwm_input_pkg::ST_DT_A;
      next_cnt     = '0;
      next_pend_a  = 1'b0;
      next_pend_b  = 1'b0;
      next_burst_a = 1'b0;
      next_burst_b = 1'b0;
    end else if (evt_a && one_ramp) begin
      next_phase = pwm_input_pkg::ST_DT_A;
      next_cnt   = '0;
    end else if (evt_b && one_ramp) begin
      next_phase = pwm_input_pkg::ST_DT_A;
      next_cnt   = '0;
    end else if (evt_a) begin
      next_cnt   = '0;
      next_phase = (cfg_a.mode == `MODE_JUMP_WAIT) ? pwm_input_pkg::ST_WAIT_A
                                                   : pwm_input_pkg::ST_DT_B;
      next_pend_a  = (cfg_a.mode == `MODE_RUN_WAIT);
      next_burst_a = (cfg_a.mode == `MODE_BURST);
    end else if (evt_b) begin
      next_cnt   = '0;
      next_phase = (cfg_b.mode == `MODE_JUMP_WAIT) ? pwm_input_pkg::ST_WAIT_B
                                                   : pwm_input_pkg::ST_DT_A;
      next_pend_b  = (cfg_b.mode == `MODE_RUN_WAIT);
      next_burst_b = (cfg_b.mode == `MODE_BURST);
    end else if (tick) begin
      unique case (phase)
        pwm_input_pkg::ST_WAIT_A: begin
          // Mode 1 exits to the B half, mode 2 back to the A half
          if (!act_a) begin
            next_phase  = pend_a ? pwm_input_pkg::ST_DT_A : pwm_input_pkg::ST_DT_B;
            next_pend_a = 1'b0;
          end
        end
        pwm_input_pkg::ST_WAIT_B: begin
          if (!act_b) begin
            next_phase  = pend_b ? pwm_input_pkg::ST_DT_B : pwm_input_pkg::ST_DT_A;
            next_pend_b = 1'b0;
          end
        end
        pwm_input_pkg::ST_DT_A: begin
          next_cnt = end_phase ? '0 : cnt + 1'b1;
          if (end_phase) begin
            // Burst from A skips the A on-time while A stays active
            next_phase   = (burst_a && act_a) ? pwm_input_pkg::ST_DT_B
                                              : pwm_input_pkg::ST_OT_A;
            next_burst_a = burst_a && act_a;
          end
        end
        pwm_input_pkg::ST_OT_A: begin
          next_cnt = end_phase ? '0 : cnt + 1'b1;
          if (end_phase) begin
            // The A half started by B always completes before any wait
            next_phase  = (pend_b && act_b) ? pwm_input_pkg::ST_WAIT_B
                                            : pwm_input_pkg::ST_DT_B;
            next_pend_b = pend_b && act_b;
            if (burst_b && act_b) begin
              next_phase = pwm_input_pkg::ST_DT_B;
            end
          end
        end
        pwm_input_pkg::ST_DT_B: begin
          next_cnt = end_phase ? '0 : cnt + 1'b1;
          if (end_phase) begin
            next_phase   = (burst_b && act_b) ? pwm_input_pkg::ST_DT_A
                                              : pwm_input_pkg::ST_OT_B;
            next_burst_b = burst_b && act_b;
          end
        end
        pwm_input_pkg::ST_OT_B: begin
          next_cnt = end_phase ? '0 : cnt + 1'b1;
          if (end_phase) begin
            next_phase  = (pend_a && act_a) ? pwm_input_pkg::ST_WAIT_A
                                            : pwm_input_pkg::ST_DT_A;
            next_pend_a = pend_a && act_a;
          end
        end
        default: next_phase = pwm_input_pkg::ST_DT_A;
      endcase
    end
  end

  // Sequencer, prescaler and output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase   <= pwm_input_pkg::ST_DT_A;
      cnt     <= '0;
      {pend_a, pend_b, burst_a, burst_b} <= 4'h0;
      div     <= '0;
      out_a   <= 1'b0;
      out_b   <= 1'b0;
    end else begin
      phase   <= next_phase;
      cnt     <= next_cnt;
      {pend_a, pend_b, burst_a, burst_b} <= {next_pend_a, next_pend_b, next_burst_a, next_burst_b};
      div     <= tick ? '0 : div + 1'b1;
      out_a   <= run_on && (phase == pwm_input_pkg::ST_OT_A) && !force_off;
      out_b   <= run_on && (phase == pwm_input_pkg::ST_OT_B) && !force_off;
    end
  end

  // Clockless kill path: a stopped stage clock cannot hold the outputs on
  assign output_a_pin = out_a && !(cfg_a.async_out && raw_a);
  assign output_b_pin = out_b && !(cfg_b.async_out && raw_b);

  // Bus decode; one write and one read in flight, no wait on the opposite channel
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire wr_hit   = (aw_addr == `OFS_CTRL_A) || (aw_addr == `OFS_CTRL_B) ||
                  (aw_addr == `OFS_RUN) || (aw_addr == `OFS_TIME_A) || (aw_addr == `OFS_TIME_B);
  wire rd_hit   = (s_axi_araddr == `OFS_STATUS) || (s_axi_araddr == `OFS_CTRL_A) ||
                  (s_axi_araddr == `OFS_CTRL_B) || (s_axi_araddr == `OFS_RUN) ||
                  (s_axi_araddr == `OFS_TIME_A) || (s_axi_araddr == `OFS_TIME_B);
  wire pwm_input_pkg::status_type status = '{hold: !in_run, act_b: act_b, act_a: act_a,
                                             out_b: out_b, out_a: out_a, phase: phase};
  wire [31:0] rd_mux =
    (s_axi_araddr == `OFS_CTRL_A) ? input_control_reg_a :
    (s_axi_araddr == `OFS_CTRL_B) ? input_control_reg_b :
    (s_axi_araddr == `OFS_RUN)    ? run_reg :
    (s_axi_araddr == `OFS_TIME_A) ? time_a :
    (s_axi_araddr == `OFS_TIME_B) ? time_b :
    (s_axi_araddr == `OFS_STATUS) ? {24'h00_0000, status} : 32'h0000_0000;
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write channel capture and register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      input_control_reg_a <= `RST_CTRL;
      input_control_reg_b <= `RST_CTRL;
      run_reg <= `RST_RUN;
      time_a  <= `RST_TIME;
      time_b  <= `RST_TIME;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (aw_addr == `OFS_CTRL_A) input_control_reg_a <= merge(input_control_reg_a, w_data, w_strb);
        if (aw_addr == `OFS_CTRL_B) input_control_reg_b <= merge(input_control_reg_b, w_data, w_strb);
        if (aw_addr == `OFS_RUN)    run_reg <= merge(run_reg, w_data, w_strb);
        if (aw_addr == `OFS_TIME_A) time_a  <= merge(time_a, w_data, w_strb);
        if (aw_addr == `OFS_TIME_B) time_b  <= merge(time_b, w_data, w_strb);
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on sequencing and outputs
  chk_centered_no_jump: assert property (@(posedge aclk) disable iff (!aresetn)
    (centered && run_on && in_run && !end_phase && $stable(run_reg)) |=> (phase == $past(phase)))
    else $error("centered mode phase changed before its end");
  chk_retrig_jump_b: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt_a && !one_ramp && cfg_a.mode == `MODE_EDGE_RETRIG)
      |=> (phase == pwm_input_pkg::ST_DT_B) && (cnt == '0))
    else $error("edge retrigger on A did not start the B half");
  chk_one_ramp_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (one_ramp && (evt_a || evt_b)) |=> (phase == pwm_input_pkg::ST_DT_A) && (cnt == '0))
    else $error("one ramp retrigger did not restart the counter");
  chk_release_a_out: assert property (@(posedge aclk) disable iff (!aresetn)
    evt_a |-> ##2 !out_a)
    else $error("output A still on after its event");
  chk_window_b_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (!one_ramp && !centered && half_a) |-> !evt_b)
    else $error("input B evaluated during the A half");
  chk_wait_a_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase == pwm_input_pkg::ST_WAIT_A && act_a && run_on) |=>
      (phase == pwm_input_pkg::ST_WAIT_A) && !out_a)
    else $error("mode 1 wait left while input A active");
  chk_burst_skip_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase == pwm_input_pkg::ST_DT_A && burst_a && act_a && tick && end_phase && run_on &&
     !evt_b) |=> (phase == pwm_input_pkg::ST_DT_B))
    else $error("burst did not return to the B half");
  chk_force_off_both: assert property (@(posedge aclk) disable iff (!aresetn)
    force_off |=> !out_a && !out_b)
    else $error("outputs on while mode 4 input active");
  chk_async_kill_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_a.async_out && raw_a) |-> !output_a_pin)
    else $error("async control did not kill output A");

endmodule
`default_nettype wire

// [include/pwm_input_defs.svh]
// Constants for the stage controller input module: offsets, fields, resets, codes
`ifndef PWM_INPUT_DEFS_SVH
`define PWM_INPUT_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave
`define ADDR_W          8
`define OFS_CTRL_A      8'h00
`define OFS_CTRL_B      8'h04
`define OFS_RUN         8'h08
`define OFS_TIME_A      8'h0C
`define OFS_TIME_B      8'h10
`define OFS_STATUS      8'h14

// Reset values
`define RST_CTRL        32'h0000_0000
`define RST_RUN         32'h0000_0000
`define RST_TIME        32'h0010_0002

// Field positions
`define CFG_MSB         7
`define RUN_MODE_MSB    1
`define RUN_MODE_LSB    0
`define RUN_EN_BIT      2
`define PRESC_MSB       15
`define PRESC_LSB       8
`define DEAD_MSB        11
`define DEAD_LSB        0
`define ON_MSB          27
`define ON_LSB          16

// Input mode codes
`define MODE_NONE       4'h0
`define MODE_JUMP_WAIT  4'h1
`define MODE_RUN_WAIT   4'h2
`define MODE_BURST      4'h3
`define MODE_FORCE_OFF  4'h4
`define MODE_EDGE_RETRIG 4'h8

// Filter span in stage clock ticks and bus answers
`define FILTER_CYCLES   4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [include/pwm_input_pkg.sv]
// Types shared by the stage controller input module
package pwm_input_pkg;

  // Running mode of the stage counter
  typedef enum logic [1:0] {
    RUN_ONE_RAMP  = 2'b00,
    RUN_TWO_RAMP  = 2'b01,
    RUN_FOUR_RAMP = 2'b10,
    RUN_CENTERED  = 2'b11
  } run_mode_type;

  // Sequencer phases, two hold states for the waiting modes
  typedef enum logic [2:0] {
    ST_DT_A   = 3'b000,
    ST_OT_A   = 3'b001,
    ST_DT_B   = 3'b010,
    ST_OT_B   = 3'b011,
    ST_WAIT_A = 3'b100,
    ST_WAIT_B = 3'b101
  } phase_type;

  // One input control register, low byte
  typedef struct packed {
    logic       async_out;
    logic       src_cmp;
    logic       filter_en;
    logic       level_high;
    logic [3:0] mode;
  } chan_cfg_type;

  // Status word, low byte
  typedef struct packed {
    logic      hold;
    logic      act_b;
    logic      act_a;
    logic      out_b;
    logic      out_a;
    phase_type phase;
  } status_type;

endpackage

// [core/input_conditioner.sv]
// Synchroniser, digital filter and polarity stage for one fault/retrigger input
`timescale 1ns/1ps
`default_nettype none
`include "pwm_input_defs.svh"

module input_conditioner #(
  parameter int FILTER_LEN = `FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Stage clock enable
  input  wire logic tick,
  // Sources
  input  wire logic pin,
  input  wire logic comparator,
  // Configuration
  input  wire logic src_sel,
  input  wire logic filter_en,
  input  wire logic level_sel,
  // Results
  output logic      active,
  output logic      rise,
  output logic      raw_active
);

  logic                  pin_s1, pin_s2, cmp_s1, cmp_s2;
  logic [FILTER_LEN-1:0] hist;
  logic                  filt;
  logic                  prev;

  // Two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge aclk) begin
    pin_s1 <= pin;
    pin_s2 <= pin_s1;
    cmp_s1 <= comparator;
    cmp_s2 <= cmp_s1;
  end

  // Source choice, filter window and polarity
  wire                  sel_lvl = src_sel ? cmp_s2 : pin_s2;
  wire [FILTER_LEN-1:0] win     = {hist[FILTER_LEN-2:0], sel_lvl};
  wire                  all_hi  = &win;
  wire                  all_lo  = ~|win;
  wire                  next_filt = !filter_en ? sel_lvl : all_hi ? 1'b1 : all_lo ? 1'b0 : filt;
  assign active     = level_sel ? filt : ~filt;
  // Edge judged on the filtered level, so reset or a polarity flip never fakes one
  assign rise       = level_sel ? (filt & ~prev) : (~filt & prev);
  // Unsynchronised path kept only for the clockless output kill
  assign raw_active = level_sel ? (src_sel ? comparator : pin) : ~(src_sel ? comparator : pin);

  // Filter advances on the stage tick, so its span scales with the prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist <= '0;
      filt <= 1'b0;
      prev <= 1'b0;
    end else if (tick) begin
      hist <= win;
      filt <= next_filt;
      prev <= filt;
    end
  end

endmodule
`default_nettype wire

// [verification/fault_source.sv]
// Far-side model: fault pins and comparator outputs of both halves
`timescale 1ns/1ps
`default_nettype none
module fault_source (
  // Wanted levels and source in use
  input  wire logic lvl_a,
  input  wire logic lvl_b,
  input  wire logic use_cmp,
  // Lines to the design
  output logic      pin_a,
  output logic      pin_b,
  output logic      cmp_a,
  output logic      cmp_b
);
  // Unused source shows the inverse level, so a wrong selection cannot pass
  assign pin_a = use_cmp ? !lvl_a : lvl_a;
  assign cmp_a = use_cmp ? lvl_a : !lvl_a;
  assign pin_b = use_cmp ? !lvl_b : lvl_b;
  assign cmp_b = use_cmp ? lvl_b : !lvl_b;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the stage controller input module
`timescale 1ns/1ps
`default_nettype none
`include "pwm_input_defs.svh"
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, lvl_a = 1'b0, lvl_b = 1'b0, use_cmp = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_v;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin_a, pin_b, cmp_a, cmp_b;
  logic        out_a, out_b;
  logic [1:0]  bresp, rresp, rs, hi;
  logic [3:0]  code;
  int          error_cnt = 0, n_checks = 0, seed;

  // Clock, design and far side
  always #4 aclk = ~aclk;
  pwm_fault_retrigger_inputs i_pwm_fault_retrigger_inputs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_input_pin_a(pin_a), .fault_input_pin_b(pin_b), .comparator_a(cmp_a),
    .comparator_b(cmp_b), .output_a_pin(out_a), .output_b_pin(out_b));
  fault_source i_fault_source (.lvl_a(lvl_a), .lvl_b(lvl_b), .use_cmp(use_cmp),
    .pin_a(pin_a), .pin_b(pin_b), .cmp_a(cmp_a), .cmp_b(cmp_b));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes judged at the rising edge, released right after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(posedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(posedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Unmapped places and writes to the status word answer with an error
  function automatic logic [1:0] resp_of(input logic [7:0] a, input logic w);
    return (a > `OFS_STATUS || (w && a == `OFS_STATUS)) ? `RESP_SLVERR : `RESP_OKAY;
  endfunction

  function automatic logic [31:0] ctrl(input logic [3:0] m, input logic f, s, k, p = 1'b1);
    return {24'h00_0000, k, s, f, p, m};
  endfunction

  task automatic wait_on();
    int n;
    n = 0;
    while (out_a !== 1'b1 && n < 200) begin
      @(negedge aclk);
      n++;
    end
    chk(out_a, 1'b1);
  endtask

  // Which outputs were seen high over n cycles
  task automatic seen(input int n);
    hi = 2'b00;
    repeat (n) begin
      @(negedge aclk);
      hi = hi | {out_b, out_a};
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the sequence needs about one thousand cycles
  initial begin
    repeat (8000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    seed = $urandom(38);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_TIME_A, rd_v, rs);
    chk(rd_v, `RST_TIME);
    rd(`OFS_CTRL_B, rd_v, rs);
    chk(rd_v, `RST_CTRL);
    rd(8'h18, rd_v, rs);
    chk(rs, resp_of(8'h18, 1'b0));
    wr(`OFS_STATUS, 32'h0000_00ff, rs);
    chk(rs, resp_of(`OFS_STATUS, 1'b1));
    // Edge from pin, from comparator, a short glitch under filter, centered mode
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      use_cmp <= (i == 1);
      wr(`OFS_RUN, (i == 3) ? 32'h0000_0007 : 32'h0000_0005, rs);
      wr(`OFS_CTRL_A, ctrl(`MODE_EDGE_RETRIG, i == 2, i == 1, 1'b0), rs);
      wait_on();
      @(posedge aclk);
      lvl_a <= 1'b1;
      repeat (2) @(posedge aclk);
      lvl_a <= 1'b0;
      repeat (6) @(negedge aclk);
      chk(out_a, i >= 2);
      seen(8);
      chk(hi[1], i < 2);
    end
    // Level mode 1: release, hold while active, then the B half
    use_cmp <= 1'b0;
    wr(`OFS_RUN, 32'h0000_0005, rs);
    wr(`OFS_CTRL_A, ctrl(`MODE_JUMP_WAIT, 1'b0, 1'b0, 1'b0), rs);
    wait_on();
    @(posedge aclk);
    lvl_a <= 1'b1;
    repeat (8) @(posedge aclk);
    seen(40);
    chk(hi, 2'b00);
    rd(`OFS_STATUS, rd_v, rs);
    chk(rd_v[2:0], pwm_input_pkg::ST_WAIT_A);
    lvl_a <= 1'b0;
    seen(12);
    chk(hi[1], 1'b1);
    // Mode 4 in centered mode keeps both outputs off, allowed there
    wr(`OFS_RUN, 32'h0000_0007, rs);
    wr(`OFS_CTRL_A, ctrl(`MODE_FORCE_OFF, 1'b0, 1'b0, 1'b0), rs);
    lvl_a <= 1'b1;
    repeat (8) @(posedge aclk);
    seen(80);
    chk(hi, 2'b00);
    // A random reserved code with the input still active leaves outputs running
    code = (seed[0] ? 4'hf : 4'ha) + 4'(($urandom % 4) * (seed[0] ? 0 : 1));
    wr(`OFS_CTRL_A, ctrl(code, 1'b0, 1'b0, 1'b0), rs);
    seen(80);
    chk(hi, 2'b11);
    // Low polarity burst from A: only the B half runs while A is low
    wr(`OFS_RUN, 32'h0000_0005, rs);
    wr(`OFS_CTRL_A, ctrl(`MODE_BURST, 1'b0, 1'b0, 1'b0, 1'b0), rs);
    wait_on();
    @(posedge aclk);
    lvl_a <= 1'b0;
    repeat (8) @(posedge aclk);
    seen(80);
    chk(hi, 2'b10);
    @(posedge aclk);
    lvl_a <= 1'b1;
    seen(60);
    chk(hi[0], 1'b1);
    // One ramp: B edges keep restarting the ramp, so B never reaches its on-time
    wr(`OFS_RUN, 32'h0000_0004, rs);
    wr(`OFS_CTRL_B, ctrl(`MODE_EDGE_RETRIG, 1'b0, 1'b0, 1'b0), rs);
    lvl_b <= 1'b1;
    repeat (8) @(posedge aclk);
    hi = 2'b00;
    repeat (16) begin
      @(posedge aclk);
      lvl_b <= !lvl_b;
      repeat (5) @(negedge aclk) hi = hi | {out_b, out_a};
    end
    chk(hi, 2'b01);
    @(posedge aclk);
    lvl_a <= 1'b0;
    // Async control drops the output at once with no clock edge
    wr(`OFS_CTRL_A, ctrl(`MODE_NONE, 1'b0, 1'b0, 1'b1), rs);
    wait_on();
    @(posedge aclk);
    lvl_a <= 1'b1;
    #1;
    chk(out_a, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
